// *** design/irq_ctrl_pkg.sv ***
// Package: constants, encodings and carrier types of the interrupt controller
package irq_ctrl_pkg;
  localparam int NUM_VECT = 32;
  localparam int VECT_W = 5;
  localparam int FIRST_SW_VECT = 1;
  localparam int LAST_SW_VECT = 31;
  localparam logic [1:0] PRIO_LVL0 = 2'h2;
  localparam logic [1:0] PRIO_LVL1 = 2'h1;
  localparam logic [1:0] PRIO_LVL2 = 2'h0;
  localparam logic [1:0] PRIO_LVL3 = 2'h3;
  localparam logic [1:0] PRIO_RESET_VAL = 2'h3;
  localparam int CCR_MASK_HI_POS = 5;
  localparam int CCR_MASK_LO_POS = 3;
  localparam logic [7:0] CCR_RESET_VAL = 8'h28;
  localparam int NUM_STACKED = 5;
  localparam int HALT_INSTR_CYCLES = 9;
  localparam int NUM_PERIPH = 8;
  localparam int NUM_PINS = 8;
  localparam int PIN_IRQ_VECT = 3;
  localparam int PERIPH_BASE_VECT = 8;
  localparam int NMI_VECT = 2;
  localparam int NUM_NMI_PORTS = 3;
  localparam logic [4:0] RESET_CODE = 5'h00;
  localparam logic [4:0] TRAP_CODE = 5'h01;
  localparam logic [31:0] AXI_OFF_PRIO0 = 32'h0000_0000;
  localparam logic [31:0] AXI_OFF_PRIO1 = 32'h0000_0004;
  localparam logic [31:0] AXI_OFF_ENABLE = 32'h0000_0008;
  localparam logic [31:0] AXI_OFF_PENDING = 32'h0000_000C;
  localparam logic [31:0] AXI_OFF_STATUS = 32'h0000_0010;
  localparam logic [31:0] AXI_OFF_NMI_ROUTE = 32'h0000_0014;
  localparam logic [31:0] AXI_OFF_PIN_SEL = 32'h0000_0018;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CPU_RUN, CPU_FINISH, CPU_STACK, CPU_VECTOR, CPU_UNSTACK, CPU_HALTING, CPU_HALTED, CPU_WAIT
  } cpu_state_t;

  typedef struct packed {
    logic instr_done;
    logic trap;
    logic interrupt_return_instr;
    logic sim;
    logic reset_mask_instr;
    logic halt;
    logic wait_for_irq_instr;
  } core_evt_t;

  typedef struct packed {
    logic irq;
    logic nmi;
    logic [VECT_W-1:0] vect;
  } core_req_t;

  function automatic logic [1:0] prio_rank(input logic [1:0] code);
    case (code)
      PRIO_LVL0: prio_rank = 2'd0;
      PRIO_LVL1: prio_rank = 2'd1;
      PRIO_LVL2: prio_rank = 2'd2;
      default: prio_rank = 2'd3;
    endcase
  endfunction
endpackage

// *** design/irq_ctrl.sv ***
// Prioritised vectored interrupt controller with CPU entry/return sequencer
// How it works
// - The current instruction finishes before entry begins.
// - Entry stacks PC, both index registers, accumulator and flags.
// - Maskable entry loads the mask bits with the serviced vector's priority field.
// - After stacking the vector is loaded and the handler fetch starts in that same cycle.
// - Return pops all stacked registers including the mask bits.
// - Unmasking after a set-mask inside a handler drops priority to level 0.
// - Priority fields share the mask-bit encoding: 10,01,00,11.
// - A write of pattern 10 to a priority field is ignored.
// - Priority fields exist for vectors 1 to 31 only.
// - Highest software priority wins, ties by hardware order; NMI sources top.
// - Requests are not held: pending follows each pin, port and peripheral level every cycle.
// - Non-maskable entries ignore the mask and set level 3.
// - Trap is taken on the trap instruction and never leaves halt.
// - Reset ranks highest, leaves masks closed, and leaves halt.
// - Hardware NMI is served at once and wakes from halt.
// - Maskable request needs enable and priority above mask; ports may be NMI.
// - Selected pins sharing a line are ORed.
// - Level request stays pending after return while level remains.
// - Peripheral request needs its flag and its enable.
// - Status then field access clears the latch and loses the pending request.
// - Any request ends wait; halt wake serves NMI first, else a wake-capable source.
// - Requests during halt let the 9-cycle halt finish, then wake.
// - Outputs: maskable request, non-maskable request and 5-bit vector code.
// - Mask bits sit at flag bits 5 and 3.
// - Peripheral request inputs are level sensitive, active high.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int HALT_CYCLES = HALT_INSTR_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [31:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [31:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_FLAG_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_EN_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_CLEAR_IN,
  input wire logic [NUM_PINS-1:0] PIN_LEVEL_IN,
  input wire logic [NUM_NMI_PORTS-1:0] PORT_REQ_IN,
  input wire logic HW_NMI_IN,
  input wire logic [NUM_VECT-1:0] WAKE_CAPABLE_IN,
  input wire core_evt_t CORE_EVT_IN,
  output core_req_t CORE_REQ_OUT,
  output logic [7:0] CCR_OUT,
  output logic [2:0] STACK_IDX_OUT,
  output logic STACK_PUSH_OUT,
  output logic STACK_POP_OUT,
  output logic VECT_LOAD_OUT,
  output logic FETCH_OUT,
  output logic HALTED_OUT,
  output logic WAITING_OUT
);
  initial begin
    if (HALT_CYCLES < 1 || HALT_CYCLES > 255) begin
      $error("HALT_CYCLES out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request collection
  logic [NUM_VECT-1:0] raw_req;
  logic [NUM_VECT-1:0] pending;
  logic [NUM_VECT-1:0] next_pending;
  logic [NUM_VECT-1:0] enable;
  logic [NUM_NMI_PORTS-1:0] nmi_route;
  logic [NUM_PINS-1:0] pin_sel;
  logic [1:0] vprio [NUM_VECT];
  logic [1:0] next_vprio [NUM_VECT];
  logic nmi_line;

  always_comb begin
    raw_req = '0;
    raw_req[PIN_IRQ_VECT] = |(PIN_LEVEL_IN & pin_sel);
    for (int i = 0; i < NUM_NMI_PORTS; i++) begin
      raw_req[4 + i] = PORT_REQ_IN[i] & ~nmi_route[i];
    end
    for (int i = 0; i < NUM_PERIPH; i++) begin
      raw_req[PERIPH_BASE_VECT + i] = PERIPH_FLAG_IN[i] & PERIPH_EN_IN[i];
    end
  end

  assign nmi_line = HW_NMI_IN | (|(PORT_REQ_IN & nmi_route));

  // Peripheral latches follow their level; a clear sequence wins over the level
  always_comb begin
    next_pending = pending | raw_req;
    next_pending[PIN_IRQ_VECT] = raw_req[PIN_IRQ_VECT];
    for (int i = 0; i < NUM_PERIPH; i++) begin
      if (PERIPH_CLEAR_IN[i]) begin
        next_pending[PERIPH_BASE_VECT + i] = 1'b0;
      end else begin
        next_pending[PERIPH_BASE_VECT + i] = raw_req[PERIPH_BASE_VECT + i];
      end
    end
    for (int i = 0; i < NUM_NMI_PORTS; i++) begin
      next_pending[4 + i] = raw_req[4 + i];
    end
    next_pending[0] = 1'b0;
    next_pending[NMI_VECT] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic [1:0] cur_rank;
  logic best_found;
  logic [VECT_W-1:0] best_vect;
  logic [1:0] best_rank;
  logic [NUM_VECT-1:0] eligible;
  logic halt_mode;

  always_comb begin
    best_found = 1'b0;
    best_vect = '0;
    best_rank = '0;
    cur_rank = prio_rank({CCR_OUT[CCR_MASK_HI_POS], CCR_OUT[CCR_MASK_LO_POS]});
    eligible = pending & enable;
    if (halt_mode) begin
      eligible = eligible & WAKE_CAPABLE_IN;
    end
    // Lowest number wins ties: scan downward so later hits override
    for (int i = LAST_SW_VECT; i >= FIRST_SW_VECT; i--) begin
      if (eligible[i] && prio_rank(vprio[i]) > cur_rank
          && (!best_found || prio_rank(vprio[i]) >= best_rank)) begin
        best_found = 1'b1;
        best_vect = VECT_W'(i);
        best_rank = prio_rank(vprio[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU sequencer
  cpu_state_t state;
  cpu_state_t next_state;
  logic [7:0] condition_code_reg;
  logic [7:0] next_ccr;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] halt_cnt;
  logic [7:0] next_halt_cnt;
  logic [VECT_W-1:0] serv_vect;
  logic [VECT_W-1:0] next_serv_vect;
  logic [1:0] serv_lvl;
  logic [1:0] next_serv_lvl;
  // Saved mask levels, newest in the low bits
  logic [7:0] mask_stack;
  logic [7:0] next_mask_stack;
  logic is_nmi;
  logic next_is_nmi;
  logic wake_req;

  assign CCR_OUT = condition_code_reg;
  assign halt_mode = (state == CPU_HALTED) || (state == CPU_HALTING);
  assign wake_req = best_found | nmi_line;

  always_comb begin
    next_state = state;
    next_ccr = condition_code_reg;
    next_cnt = cnt;
    next_halt_cnt = halt_cnt;
    next_serv_vect = serv_vect;
    next_serv_lvl = serv_lvl;
    next_mask_stack = mask_stack;
    next_is_nmi = is_nmi;
    case (state)
      CPU_RUN: begin
        if (CORE_EVT_IN.trap) begin
          next_state = CPU_FINISH;
          next_serv_vect = TRAP_CODE;
          next_is_nmi = 1'b1;
        end else if (nmi_line) begin
          next_state = CPU_FINISH;
          next_serv_vect = VECT_W'(NMI_VECT);
          next_is_nmi = 1'b1;
        end else if (best_found) begin
          next_state = CPU_FINISH;
          next_serv_vect = best_vect;
          next_serv_lvl = vprio[best_vect];
          next_is_nmi = 1'b0;
        end else if (CORE_EVT_IN.halt) begin
          next_state = CPU_HALTING;
          next_halt_cnt = '0;
          next_ccr[CCR_MASK_HI_POS] = 1'b1;
          next_ccr[CCR_MASK_LO_POS] = 1'b0;
        end else if (CORE_EVT_IN.wait_for_irq_instr) begin
          next_state = CPU_WAIT;
          next_ccr[CCR_MASK_HI_POS] = 1'b1;
          next_ccr[CCR_MASK_LO_POS] = 1'b0;
        end else if (CORE_EVT_IN.interrupt_return_instr) begin
          next_state = CPU_UNSTACK;
          next_cnt = '0;
        end else if (CORE_EVT_IN.sim) begin
          next_ccr[CCR_MASK_HI_POS] = 1'b1;
          next_ccr[CCR_MASK_LO_POS] = 1'b1;
        end else if (CORE_EVT_IN.reset_mask_instr) begin
          // A handler that masked and unmasks ends up at level 0
          next_ccr[CCR_MASK_HI_POS] = PRIO_LVL0[1];
          next_ccr[CCR_MASK_LO_POS] = PRIO_LVL0[0];
        end
      end
      CPU_FINISH: begin
        if (CORE_EVT_IN.instr_done) begin
          next_state = CPU_STACK;
          next_cnt = '0;
        end
      end
      CPU_STACK: begin
        next_cnt = cnt + 3'd1;
        if (cnt == 3'(NUM_STACKED - 1)) begin
          next_state = CPU_VECTOR;
          next_mask_stack = {mask_stack[5:0], condition_code_reg[CCR_MASK_HI_POS], condition_code_reg[CCR_MASK_LO_POS]};
          if (is_nmi) begin
            next_ccr[CCR_MASK_HI_POS] = PRIO_LVL3[1];
            next_ccr[CCR_MASK_LO_POS] = PRIO_LVL3[0];
          end else begin
            next_ccr[CCR_MASK_HI_POS] = serv_lvl[1];
            next_ccr[CCR_MASK_LO_POS] = serv_lvl[0];
          end
        end
      end
      CPU_VECTOR: begin
        next_state = CPU_RUN;
      end
      CPU_UNSTACK: begin
        next_cnt = cnt + 3'd1;
        if (cnt == 3'(NUM_STACKED - 1)) begin
          next_state = CPU_RUN;
          next_ccr = CCR_RESET_VAL & 8'h00; // Flags come back from the stack via the core
          next_ccr[CCR_MASK_HI_POS] = mask_stack[1];
          next_ccr[CCR_MASK_LO_POS] = mask_stack[0];
          next_mask_stack = {PRIO_LVL0, mask_stack[7:2]};
        end
      end
      CPU_HALTING: begin
        // Halt instruction always runs to completion before any wake
        next_halt_cnt = halt_cnt + 8'd1;
        if (halt_cnt == 8'(HALT_CYCLES - 1)) begin
          next_state = wake_req ? CPU_RUN : CPU_HALTED;
        end
      end
      CPU_HALTED: begin
        if (wake_req) begin
          next_state = CPU_RUN;
        end
      end
      CPU_WAIT: begin
        if (wake_req || (|pending)) begin
          next_state = CPU_RUN;
        end
      end
      default: next_state = CPU_RUN;
    endcase
    // Waking goes straight to entry with the NMI, else the wake-capable winner
    if (halt_mode && next_state == CPU_RUN) begin
      next_state = CPU_FINISH;
      next_is_nmi = nmi_line;
      next_serv_vect = nmi_line ? VECT_W'(NMI_VECT) : best_vect;
      next_serv_lvl = vprio[best_vect];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= CPU_RUN;
      condition_code_reg <= CCR_RESET_VAL;
      cnt <= '0;
      halt_cnt <= '0;
      serv_vect <= RESET_CODE;
      serv_lvl <= PRIO_RESET_VAL;
      mask_stack <= {4{PRIO_LVL0}};
      is_nmi <= 1'b0;
      pending <= '0;
    end else if (CE_IN) begin
      state <= next_state;
      condition_code_reg <= next_ccr;
      cnt <= next_cnt;
      halt_cnt <= next_halt_cnt;
      serv_vect <= next_serv_vect;
      serv_lvl <= next_serv_lvl;
      mask_stack <= next_mask_stack;
      is_nmi <= next_is_nmi;
      pending <= next_pending;
    end
  end

  always_comb begin
    CORE_REQ_OUT.irq = best_found;
    CORE_REQ_OUT.nmi = nmi_line;
    CORE_REQ_OUT.vect = nmi_line ? VECT_W'(NMI_VECT) : best_vect;
  end
  assign STACK_PUSH_OUT = (state == CPU_STACK);
  assign STACK_POP_OUT = (state == CPU_UNSTACK);
  assign STACK_IDX_OUT = cnt;
  assign VECT_LOAD_OUT = (state == CPU_VECTOR);
  assign FETCH_OUT = (state == CPU_VECTOR);
  assign HALTED_OUT = (state == CPU_HALTED);
  assign WAITING_OUT = (state == CPU_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave
  logic aw_ok;
  logic w_ok;
  logic [31:0] awaddr;
  logic [31:0] wdata;
  logic bvalid;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic next_aw_ok;
  logic next_w_ok;
  logic [31:0] next_awaddr;
  logic [31:0] next_wdata;
  logic next_bvalid;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;
  logic [NUM_VECT-1:0] next_enable;
  logic [NUM_NMI_PORTS-1:0] next_nmi_route;
  logic [NUM_PINS-1:0] next_pin_sel;

  assign S_AXI_AWREADY_OUT = !aw_ok && !bvalid;
  assign S_AXI_WREADY_OUT = !w_ok && !bvalid;
  assign S_AXI_ARREADY_OUT = !rvalid;
  assign S_AXI_BVALID_OUT = bvalid;
  assign S_AXI_BRESP_OUT = bresp;
  assign S_AXI_RVALID_OUT = rvalid;
  assign S_AXI_RDATA_OUT = rdata;
  assign S_AXI_RRESP_OUT = rresp;

  always_comb begin
    next_aw_ok = aw_ok;
    next_w_ok = w_ok;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_enable = enable;
    next_nmi_route = nmi_route;
    next_pin_sel = pin_sel;
    for (int i = 0; i < NUM_VECT; i++) begin
      next_vprio[i] = vprio[i];
    end
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      next_aw_ok = 1'b1;
      next_awaddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      next_w_ok = 1'b1;
      next_wdata = S_AXI_WDATA_IN;
    end
    if (aw_ok && w_ok) begin
      next_aw_ok = 1'b0;
      next_w_ok = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case ({awaddr[31:2], 2'b00})
        AXI_OFF_PRIO0, AXI_OFF_PRIO1: begin
          for (int i = 0; i < 16; i++) begin
            int v;
            v = (awaddr[2] ? 16 : 0) + i;
            // Level-0 pattern cannot be programmed; field keeps old value
            if (v >= FIRST_SW_VECT && wdata[2*i +: 2] != PRIO_LVL0) begin
              next_vprio[v] = wdata[2*i +: 2];
            end
          end
        end
        AXI_OFF_ENABLE: next_enable = wdata;
        AXI_OFF_NMI_ROUTE: next_nmi_route = wdata[NUM_NMI_PORTS-1:0];
        AXI_OFF_PIN_SEL: next_pin_sel = wdata[NUM_PINS-1:0];
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && S_AXI_BREADY_IN) begin
      next_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      case ({S_AXI_ARADDR_IN[31:2], 2'b00})
        AXI_OFF_PRIO0: for (int i = 0; i < 16; i++) next_rdata[2*i +: 2] = vprio[i];
        AXI_OFF_PRIO1: for (int i = 0; i < 16; i++) next_rdata[2*i +: 2] = vprio[16 + i];
        AXI_OFF_ENABLE: next_rdata = enable;
        AXI_OFF_PENDING: next_rdata = pending;
        AXI_OFF_STATUS: next_rdata = {16'h0000, 3'(state), serv_vect, condition_code_reg};
        AXI_OFF_NMI_ROUTE: next_rdata[NUM_NMI_PORTS-1:0] = nmi_route;
        AXI_OFF_PIN_SEL: next_rdata[NUM_PINS-1:0] = pin_sel;
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && S_AXI_RREADY_IN) begin
      next_rvalid = 1'b0;
    end
    next_vprio[0] = PRIO_LVL3;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      awaddr <= '0;
      wdata <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      enable <= '0;
      nmi_route <= '0;
      pin_sel <= '0;
      for (int i = 0; i < NUM_VECT; i++) begin
        vprio[i] <= PRIO_RESET_VAL;
      end
    end else if (CE_IN) begin
      aw_ok <= next_aw_ok;
      w_ok <= next_w_ok;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      enable <= next_enable;
      nmi_route <= next_nmi_route;
      pin_sel <= next_pin_sel;
      for (int i = 0; i < NUM_VECT; i++) begin
        vprio[i] <= next_vprio[i];
      end
    end
  end
endmodule // irq_ctrl

// *** test/irq_ctrl_asserts.sv ***
// Concurrent checks on the interrupt controller ports
`timescale 1ns/10ps
module irq_ctrl_asserts
  import irq_ctrl_pkg::*;
#(
  parameter int HALT_CYCLES = HALT_INSTR_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic HW_NMI_IN,
  input wire core_evt_t CORE_EVT_IN,
  input wire core_req_t CORE_REQ_OUT,
  input wire logic [7:0] CCR_OUT,
  input wire logic [2:0] STACK_IDX_OUT,
  input wire logic STACK_PUSH_OUT,
  input wire logic STACK_POP_OUT,
  input wire logic VECT_LOAD_OUT,
  input wire logic FETCH_OUT,
  input wire logic HALTED_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////
  // Cycles since the last halt request; saturates so it idles high
  logic [7:0] halt_cnt;
  logic [7:0] next_halt_cnt;
  always_comb begin
    next_halt_cnt = halt_cnt;
    if (CORE_EVT_IN.halt) begin
      next_halt_cnt = 8'h00;
    end else if (halt_cnt != 8'hFF) begin
      next_halt_cnt = halt_cnt + 8'h01;
    end
  end
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      halt_cnt <= 8'hFF;
    end else begin
      halt_cnt <= next_halt_cnt;
    end
  end
  ////////////////////////////////
  a_ccr_reset: assert property ($rose(RST_N_IN) |-> CCR_OUT == CCR_RESET_VAL)
    else $error("flags not masked after reset");
  a_push_five: assert property ($rose(STACK_PUSH_OUT) |-> STACK_PUSH_OUT[*5] ##1 !STACK_PUSH_OUT)
    else $error("push burst not five cycles");
  a_push_index: assert property (STACK_PUSH_OUT && $past(STACK_PUSH_OUT) |->
    STACK_IDX_OUT == $past(STACK_IDX_OUT) + 3'h1)
    else $error("stack index did not advance");
  // Halted wake has no instruction boundary, so it counts as one
  a_entry_boundary: assert property ($rose(STACK_PUSH_OUT) |->
    $past(CORE_EVT_IN.instr_done) || $past(CORE_EVT_IN.instr_done, 2) ||
    $past(CORE_EVT_IN.trap) || $past(HALTED_OUT) || $past(HALTED_OUT, 2))
    else $error("entry began mid instruction");
  a_vect_load: assert property ($fell(STACK_PUSH_OUT) |-> ##[0:2] VECT_LOAD_OUT)
    else $error("no vector load after stacking");
  a_fetch_after: assert property (VECT_LOAD_OUT |-> ##[0:2] FETCH_OUT)
    else $error("no fetch after vector load");
  a_pop_five: assert property ($rose(STACK_POP_OUT) |-> STACK_POP_OUT[*5] ##1 !STACK_POP_OUT)
    else $error("pop burst not five cycles");
  a_irq_above: assert property (CORE_REQ_OUT.irq |->
    !(CCR_OUT[CCR_MASK_HI_POS] && CCR_OUT[CCR_MASK_LO_POS]))
    else $error("maskable request while masked");
  a_nmi_prompt: assert property ($rose(HW_NMI_IN) && !HALTED_OUT |-> ##[0:2] CORE_REQ_OUT.nmi)
    else $error("hardware nmi not presented");
  a_trap_stays: assert property (HALTED_OUT && CORE_EVT_IN.trap && !HW_NMI_IN
    && !CORE_REQ_OUT.irq |=> HALTED_OUT)
    else $error("trap left halt");
  a_halt_nine: assert property (int'(halt_cnt) < HALT_CYCLES |-> !HALTED_OUT)
    else $error("halt ended its instruction early");
  a_nmi_wake: assert property (HALTED_OUT && HW_NMI_IN |-> ##[1:4] !HALTED_OUT)
    else $error("nmi did not wake from halt");
  c_entry: cover property ($rose(FETCH_OUT));
  c_halted: cover property ($rose(HALTED_OUT));
  c_nmi_entry: cover property (CORE_REQ_OUT.nmi && STACK_PUSH_OUT);
endmodule // irq_ctrl_asserts

bind irq_ctrl irq_ctrl_asserts #(.HALT_CYCLES(HALT_CYCLES)) u_chk (.CLK_IN, .RST_N_IN,
  .HW_NMI_IN, .CORE_EVT_IN, .CORE_REQ_OUT, .CCR_OUT, .STACK_IDX_OUT, .STACK_PUSH_OUT,
  .STACK_POP_OUT, .VECT_LOAD_OUT, .FETCH_OUT, .HALTED_OUT);

// *** test/cpu_core_model.sv ***
// Behavioural core: instruction boundaries plus bench-issued events
`timescale 1ns/10ps
module cpu_core_model
  import irq_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic halted_in,
  input wire core_evt_t ops_in,
  output core_evt_t evt_out
);
  // Slow mode ends an instruction every fourth cycle, prompt mode every cycle
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  always_comb begin
    next_cnt = cnt + 2'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end
  // A halted core runs nothing, so it reports no boundary then
  always_comb begin
    evt_out = ops_in;
    evt_out.instr_done = (!slow_in || cnt == 2'h3) && !halted_in;
  end
endmodule // cpu_core_model

// *** test/test_irq_ctrl.sv ***
// Directed bench for the interrupt controller
`timescale 1ns/10ps
module test_irq_ctrl
  import irq_ctrl_pkg::*;
;
  localparam logic [6:0] EV_TRAP = 7'h20;
  localparam logic [6:0] EV_INTERRUPT_RETURN_INSTR = 7'h10;
  localparam logic [6:0] EV_SIM = 7'h08;
  localparam logic [6:0] EV_RIM = 7'h04;
  localparam logic [6:0] EV_HALT = 7'h02;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [31:0] awa = '0, wd = '0, ara = '0, wake = '0;
  logic [3:0] ws = '0;
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
  logic [7:0] flag = '0, en = '0, clr = '0, pin = '0;
  logic nmi = 1'h0, slow = 1'h1;
  core_evt_t ops = '0;
  core_evt_t evt;
  core_req_t req;
  logic awr, wrd, bv, arr, rv, push, pop, fch, hlt, wt;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [7:0] condition_code_reg;
  int bad_count = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  ////////////////////////////////
  irq_ctrl dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'h1),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(brdy), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrdy), .PERIPH_FLAG_IN(flag),
    .PERIPH_EN_IN(en), .PERIPH_CLEAR_IN(clr), .PIN_LEVEL_IN(pin),
    .PORT_REQ_IN(pin[2:0]), .HW_NMI_IN(nmi), .WAKE_CAPABLE_IN(wake),
    .CORE_EVT_IN(evt), .CORE_REQ_OUT(req), .CCR_OUT(condition_code_reg), .STACK_IDX_OUT(),
    .STACK_PUSH_OUT(push), .STACK_POP_OUT(pop), .VECT_LOAD_OUT(), .FETCH_OUT(fch),
    .HALTED_OUT(hlt), .WAITING_OUT(wt)
  );
  cpu_core_model core (
    .clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .halted_in(hlt),
    .ops_in(ops), .evt_out(evt)
  );
  ////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  // Ready is sampled mid-cycle, where it has settled, then acted on at the edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, got;
    logic [1:0] r;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    do begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrd;
      got = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end while (!got);
    brdy <= 1'h0;
    chk("bresp", er, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
    logic ta, got;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    do begin
      @(negedge clk);
      ta = arv & arr;
      got = rv;
      r = rr;
      d = rdat;
      @(posedge clk);
      if (ta) arv <= 1'h0;
    end while (!got);
    rrdy <= 1'h0;
    chk("rresp", er, r);
    if (er === RESP_OKAY) chk("rdata", ed, d);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    ops <= e;
    @(posedge clk);
    ops <= '0;
  endtask
  // Follows one entry to its fetch, counting stack traffic on the way
  task automatic entry(input logic [4:0] ev, input logic cv, input logic [7:0] em,
                       input int epop);
    int np, npop, n;
    logic [4:0] v;
    np = 0;
    npop = 0;
    n = 0;
    v = '0;
    do begin
      @(negedge clk);
      if (push && np == 0) v = req.vect;
      np += int'(push);
      npop += int'(pop);
      n++;
    end while (!fch && n < 300);
    chk("fetch", 1, fch);
    chk("pushes", 5, np);
    chk("pops", epop, npop);
    if (cv) chk("vect", ev, v);
    chk("mask", em, condition_code_reg & 8'h28);
  endtask
  task automatic clear(input logic [7:0] m);
    @(posedge clk);
    flag <= flag & ~m;
    clr <= m;
    @(posedge clk);
    clr <= '0;
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(negedge clk);
    chk("ccr", CCR_RESET_VAL, condition_code_reg);
    rd(AXI_OFF_PRIO1, RESP_OKAY, 32'hFFFF_FFFF);
    rd(AXI_OFF_ENABLE, RESP_OKAY, 32'h0000_0000);
    wr(AXI_OFF_PRIO1, 32'h6666_6666, RESP_OKAY);
    rd(AXI_OFF_PRIO1, RESP_OKAY, 32'h7777_7777);
    rd(32'h0000_0040, RESP_SLVERR, '0);
    wr(32'h0000_0040, '0, RESP_SLVERR);
    wr(AXI_OFF_PRIO0, 32'hFFF5_FFFF, RESP_OKAY);
    wr(AXI_OFF_PIN_SEL, 32'h0000_0005, RESP_OKAY);
    pin <= 8'h04;
    rd(AXI_OFF_PENDING, RESP_OKAY, 32'h0000_0048);
    pin <= 8'h00;
    wr(AXI_OFF_ENABLE, 32'h0000_0300, RESP_OKAY);
    flag <= 8'h03;
    en <= 8'h02;
    rd(AXI_OFF_PENDING, RESP_OKAY, 32'h0000_0200);
    en <= 8'h03;
    rd(AXI_OFF_PENDING, RESP_OKAY, 32'h0000_0300);
    pulse(EV_RIM);
    entry(5'h08, 1'h1, 8'h08, 0);
    repeat (6) @(negedge clk);
    chk("irq", 0, req.irq);
    clear(8'h01);
    pulse(EV_INTERRUPT_RETURN_INSTR);
    entry(5'h09, 1'h1, 8'h08, 5);
    rd(AXI_OFF_PENDING, RESP_OKAY, 32'h0000_0200);
    clear(8'h02);
    rd(AXI_OFF_PENDING, RESP_OKAY, 32'h0000_0000);
    pulse(EV_SIM);
    pulse(EV_RIM);
    @(negedge clk);
    chk("mask", 8'h20, condition_code_reg & 8'h28);
    slow <= 1'h0;
    pulse(EV_SIM);
    nmi <= 1'h1;
    entry(5'(NMI_VECT), 1'h1, 8'h28, 0);
    @(posedge clk);
    nmi <= 1'h0;
    pulse(EV_INTERRUPT_RETURN_INSTR);
    repeat (8) @(posedge clk);
    pulse(EV_TRAP);
    entry(TRAP_CODE, 1'h0, 8'h28, 0);
    pulse(EV_INTERRUPT_RETURN_INSTR);
    repeat (8) @(posedge clk);
    pulse(7'h01);
    @(negedge clk);
    chk("waiting", 1, wt);
    @(posedge clk);
    pin <= 8'h04;
    repeat (3) @(negedge clk);
    chk("waiting", 0, wt);
    @(posedge clk);
    pin <= 8'h00;
    wake <= '1;
    pulse(EV_HALT);
    repeat (HALT_INSTR_CYCLES + 2) @(negedge clk);
    chk("halted", 1, hlt);
    pulse(EV_TRAP);
    @(negedge clk);
    chk("halted", 1, hlt);
    @(posedge clk);
    nmi <= 1'h1;
    entry(5'(NMI_VECT), 1'h1, 8'h28, 0);
    chk("halted", 0, hlt);
    @(posedge clk);
    nmi <= 1'h0;
    report_and_stop();
  end
endmodule // test_irq_ctrl
